// [hw/ulft_pkg.sv]
// package: register map, field layout and carriers for the usb line flag block
// What this block does
// - serial control bits 6,5,4 read differential, D- and D+ receivers
// - serial control bits 3 and 2 drive single-ended-zero request and tx level
// - serial control bit 1 is active-low transmit enable, resets to one
// - serial control bit 0 selects full/low speed serial mode, resets zero
// - non-sticky flags reload from their current sources when the next packet begins
// - flag 6 sets on token with good crc5, pid check and matching address
// - flags 5,4,3 set on line state SE0, K and J
// - flag 2 sets when a data packet fails crc16
// - flag 1 follows receive active, flag 0 follows receive error
// - hold bits 6:0; held flag keeps value until software writes one
// - non-held flags 5,4,3,1,0 update freely; non-held flags 6 and 2 stay set until the next packet begins
// - four 8-bit port masks; port high when any selected flag high
// - 11-bit frame count in bits 10:8 and 7:0, read/write, resets zero
// - last packet identifier in bits 3:0, read only, resets zero
// - last endpoint in bits 3:0, bit 4 set when endpoint valid
// - endpoint mark bits 15:0; marked endpoint presented ORed with 0x10
// - 7-bit device address compared to token address, resets zero
package ulft_pkg;
    // ==========================================================
    // register offsets
    localparam logic [7:0] ULFT_OFS_ADDR   = 8'h08;
    localparam logic [7:0] ULFT_OFS_SERIAL = 8'h18;
    localparam logic [7:0] ULFT_OFS_FLAGS  = 8'h1C;
    localparam logic [7:0] ULFT_OFS_HOLD   = 8'h20;
    localparam logic [7:0] ULFT_OFS_MASKS  = 8'h24;
    localparam logic [7:0] ULFT_OFS_FRAME  = 8'h28;
    localparam logic [7:0] ULFT_OFS_IDENT  = 8'h2C;
    localparam logic [7:0] ULFT_OFS_EP     = 8'h30;
    localparam logic [7:0] ULFT_OFS_MARK   = 8'h34;
    // ==========================================================
    // field positions
    localparam int ULFT_SER_DIFF   = 6;
    localparam int ULFT_SER_DM     = 5;
    localparam int ULFT_SER_DP     = 4;
    localparam int ULFT_SER_SE0    = 3;
    localparam int ULFT_SER_LEVEL  = 2;
    localparam int ULFT_SER_TXEN_N = 1;
    localparam int ULFT_SER_FSLS   = 0;
    localparam int ULFT_FLG_TOKEN  = 6;
    localparam int ULFT_FLG_SE0    = 5;
    localparam int ULFT_FLG_K      = 4;
    localparam int ULFT_FLG_J      = 3;
    localparam int ULFT_FLG_CRC16  = 2;
    localparam int ULFT_FLG_RXACT  = 1;
    localparam int ULFT_FLG_RXERR  = 0;
    localparam int ULFT_EP_VALID   = 4;
    localparam int ULFT_NPORTS     = 4;
    localparam int ULFT_MASK_W     = 8;
    // ==========================================================
    // reset values and constants
    localparam logic [3:0] ULFT_SER_RESET = 4'h2;
    localparam logic [7:0] ULFT_EP_MARK_OR = 8'h10;
    localparam logic [1:0] ULFT_LS_SE0 = 2'h0;
    localparam logic [1:0] ULFT_LS_J   = 2'h1;
    localparam logic [1:0] ULFT_LS_K   = 2'h2;
    // ==========================================================
    // carriers
    typedef struct packed {
        logic        sel;
        logic        wr;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } ulft_bus_req_t;
    typedef struct packed {
        logic        token_ok;
        logic [3:0]  ident;
        logic [6:0]  addr;
        logic [3:0]  endp;
        logic        crc16_bad;
        logic        pkt_start;
    } ulft_pkt_t;
    typedef struct packed {
        logic [1:0] linestate;
        logic       rx_active;
        logic       rx_error;
        logic       rx_diff;
        logic       rx_dm;
        logic       rx_dp;
    } ulft_line_t;
    typedef struct packed {
        logic [2:0] s1;
        logic [2:0] s2;
        logic [2:0] s3;
    } ulft_sync_t;
endpackage : ulft_pkg

// [hw/ulft_sync3.sv]
// module: three-stage synchroniser for the receiver pins
`timescale 1ns/1ps
`default_nettype none
module ulft_sync3 #(
    parameter logic [2:0] RST_VAL = 3'h0   // chain level while in reset
) (
    input  wire logic       clk_sys,   // system clock
    input  wire logic       sys_rst,   // async reset, high
    input  wire logic [2:0] pin_in,    // raw pins
    output logic      [2:0] pin_out    // agreed level
);
    import ulft_pkg::*;
    ulft_sync_t st_reg;
    ulft_sync_t st_next;
    logic [2:0] out_reg;
    logic [2:0] out_next;
    // ==========================================================
    // shift chain; change taken once stages two and three agree
    always_comb begin
        st_next.s1 = pin_in;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        out_next   = out_reg;
        for (int i = 0; i < 3; i++) begin
            if (st_reg.s2[i] == st_reg.s3[i]) begin
                out_next[i] = st_reg.s3[i];
            end
        end
    end
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            st_reg  <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL};
            out_reg <= RST_VAL;
        end else begin
            st_reg  <= st_next;
            out_reg <= out_next;
        end
    end
    assign pin_out = out_reg;
endmodule : ulft_sync3
`default_nettype wire

// [hw/ulft_top.sv]
// module: usb line control, event flags, frame count and packet capture registers
`timescale 1ns/1ps
`default_nettype none
module ulft_top (
    input  wire logic                    clk_sys,      // system clock, 50 MHz
    input  wire logic                    sys_rst,      // async reset, high
    input  wire logic                    soft_rst,     // module soft reset pulse
    input  wire ulft_pkg::ulft_bus_req_t bus_req,      // peripheral access
    output logic [31:0]                  bus_rdata,    // read data
    input  wire ulft_pkg::ulft_line_t    line_in,      // transceiver status pins
    input  wire ulft_pkg::ulft_pkt_t     pkt_in,       // token engine results
    output logic                         tx_se0,       // single-ended-zero request
    output logic                         tx_level,     // serial tx data level
    output logic                         tx_enable_n,  // tx enable, low active
    output logic                         fsls_serial,  // serial mode select
    output logic [3:0]                   event_port,   // flag event ports
    output logic [7:0]                   rx_ep_port,   // endpoint on receive port
    output logic                         pkt_accept    // token for this device
);
    import ulft_pkg::*;
    default clocking cb_sys @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    typedef struct packed {
        logic [6:0]  dev_addr;
        logic [3:0]  serial;
        logic [6:0]  flags;
        logic [6:0]  hold;
        logic [31:0] masks;
        logic [10:0] frame;
        logic [3:0]  ident;
        logic [4:0]  endp;
        logic [15:0] mark;
        logic [31:0] rdata;
        logic [7:0]  rx_ep;
        logic        accept;
        logic [1:0]  ls_q;
        logic        act_q;
        logic        err_q;
    } ulft_state_t;

    ulft_state_t s_reg;
    ulft_state_t s_next;
    logic [2:0]  rcv_sync;
    logic [1:0]  ls_sync;
    logic        act_sync;
    logic        err_sync;
    logic [6:0]  flag_set;
    logic [6:0]  flag_clr;
    logic        addr_hit;
    logic [1:0]  rcv_unused;   // spare outputs of the error chain

    // ==========================================================
    // pin synchronisers: receivers and line status come from the phy
    ulft_sync3 u_rcv (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .pin_in  ({line_in.rx_diff, line_in.rx_dm, line_in.rx_dp}),
        .pin_out (rcv_sync)
    );
    // line state leaves reset at J so no false SE0 flag follows reset
    ulft_sync3 #(.RST_VAL({ULFT_LS_J, 1'b0})) u_line (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .pin_in  ({line_in.linestate, line_in.rx_active}),
        .pin_out ({ls_sync, act_sync})
    );
    // rx error shares no chain slot, so a third instance carries it
    ulft_sync3 u_err (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .pin_in  ({2'h0, line_in.rx_error}),
        .pin_out ({rcv_unused, err_sync})
    );

    // read value of a register; reserved bits are zero
    function automatic logic [31:0] rd_mux(input ulft_state_t s, input logic [7:0] a,
                                           input logic [2:0] rcv);
        logic [31:0] v;
        v = 32'h0;
        case (a)
            ULFT_OFS_ADDR:   v[6:0]  = s.dev_addr;
            ULFT_OFS_SERIAL: v[6:0]  = {rcv, s.serial};
            ULFT_OFS_FLAGS:  v[6:0]  = s.flags;
            ULFT_OFS_HOLD:   v[6:0]  = s.hold;
            ULFT_OFS_MASKS:  v       = s.masks;
            ULFT_OFS_FRAME:  v[10:0] = s.frame;
            ULFT_OFS_IDENT:  v[3:0]  = s.ident;
            ULFT_OFS_EP:     v[4:0]  = s.endp;
            ULFT_OFS_MARK:   v[15:0] = s.mark;
            default:         v       = 32'h0;
        endcase
        return v;
    endfunction

    // ==========================================================
    // flag sources and clears
    always_comb begin
        addr_hit = (pkt_in.addr == s_reg.dev_addr);
        flag_set = 7'h0;
        flag_set[ULFT_FLG_TOKEN] = pkt_in.token_ok & addr_hit;
        flag_set[ULFT_FLG_SE0]   = (ls_sync == ULFT_LS_SE0);
        flag_set[ULFT_FLG_K]     = (ls_sync == ULFT_LS_K);
        flag_set[ULFT_FLG_J]     = (ls_sync == ULFT_LS_J);
        flag_set[ULFT_FLG_CRC16] = pkt_in.crc16_bad;
        flag_set[ULFT_FLG_RXACT] = act_sync;
        flag_set[ULFT_FLG_RXERR] = err_sync;
        flag_clr = 7'h0;
        if (bus_req.sel && bus_req.wr && bus_req.addr == ULFT_OFS_FLAGS) begin
            flag_clr = bus_req.wdata[6:0] & s_reg.hold;
        end
    end

    // ==========================================================
    // next state
    always_comb begin
        s_next        = s_reg;
        s_next.ls_q   = ls_sync;
        s_next.act_q  = act_sync;
        s_next.err_q  = err_sync;
        s_next.accept = pkt_in.token_ok & addr_hit;
        // register writes; upper bits dropped
        if (bus_req.sel && bus_req.wr) begin
            case (bus_req.addr)
                ULFT_OFS_ADDR:   s_next.dev_addr = bus_req.wdata[6:0];
                ULFT_OFS_SERIAL: s_next.serial   = bus_req.wdata[3:0];
                ULFT_OFS_HOLD:   s_next.hold     = bus_req.wdata[6:0];
                ULFT_OFS_MASKS:  s_next.masks    = bus_req.wdata;
                ULFT_OFS_MARK:   s_next.mark     = bus_req.wdata[15:0];
                default:         s_next.dev_addr = s_next.dev_addr;
            endcase
        end
        // frame count: software write
        if (bus_req.sel && bus_req.wr && bus_req.addr == ULFT_OFS_FRAME) begin
            s_next.frame = bus_req.wdata[10:0];
        end
        // flags: held bits latch ones, free bits 5,4,3,1,0 track, free bits 6,2 hold until packet start
        for (int i = 0; i < 7; i++) begin
            if (s_reg.hold[i]) begin
                if (flag_set[i]) begin
                    s_next.flags[i] = 1'b1;
                end else if (flag_clr[i]) begin
                    s_next.flags[i] = 1'b0;
                end
            end else if (pkt_in.pkt_start) begin
                s_next.flags[i] = flag_set[i];
            end else if (flag_set[i]) begin
                s_next.flags[i] = 1'b1;
            end else if (i == ULFT_FLG_RXACT || i == ULFT_FLG_RXERR ||
                         i == ULFT_FLG_SE0 || i == ULFT_FLG_K || i == ULFT_FLG_J) begin
                s_next.flags[i] = 1'b0;
            end
        end
        // packet capture
        if (pkt_in.token_ok && addr_hit) begin
            s_next.ident = pkt_in.ident;
            s_next.endp  = {1'b1, pkt_in.endp};
            s_next.rx_ep = {4'h0, pkt_in.endp};
            if (s_reg.mark[pkt_in.endp]) begin
                s_next.rx_ep = {4'h0, pkt_in.endp} | ULFT_EP_MARK_OR;
            end
        end
        s_next.rdata = bus_req.sel && !bus_req.wr ?
                       rd_mux(s_reg, bus_req.addr, rcv_sync) : s_reg.rdata;
        if (soft_rst) begin
            s_next        = '0;
            s_next.serial = ULFT_SER_RESET;
        end
    end

    // ==========================================================
    // state register; tx disabled out of reset
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            s_reg        <= '0;
            s_reg.serial <= ULFT_SER_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // ==========================================================
    // outputs
    assign tx_se0      = s_reg.serial[ULFT_SER_SE0];
    assign tx_level    = s_reg.serial[ULFT_SER_LEVEL];
    assign tx_enable_n = s_reg.serial[ULFT_SER_TXEN_N];
    assign fsls_serial = s_reg.serial[ULFT_SER_FSLS];
    assign bus_rdata   = s_reg.rdata;
    assign rx_ep_port  = s_reg.rx_ep;
    assign pkt_accept  = s_reg.accept;
    // event port: or of masked flags, combinational from flag flops
    always_comb begin
        for (int p = 0; p < ULFT_NPORTS; p++) begin
            event_port[p] = |(s_reg.flags & s_reg.masks[p*ULFT_MASK_W +: 7]);
        end
    end

    // ==========================================================
    // checks
    sequence seq_write_serial;
        bus_req.sel && bus_req.wr && bus_req.addr == ULFT_OFS_SERIAL && !soft_rst;
    endsequence
    chk_tx_enable_reset: assert property (@(posedge clk_sys)
        $fell(sys_rst) |-> tx_enable_n && !fsls_serial)
        else $error("tx enable not disabled after reset");
    chk_serial_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
        seq_write_serial |=> tx_se0 == $past(bus_req.wdata[3]) &&
                             tx_level == $past(bus_req.wdata[2]))
        else $error("serial write not reflected on tx pins");
    chk_fsls_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
        seq_write_serial |=> fsls_serial == $past(bus_req.wdata[0]))
        else $error("serial mode select wrong");
    chk_hold_keeps: assert property (@(posedge clk_sys) disable iff (sys_rst || soft_rst)
        s_reg.hold[ULFT_FLG_CRC16] && s_reg.flags[ULFT_FLG_CRC16] &&
        !(bus_req.sel && bus_req.wr && bus_req.addr == ULFT_OFS_FLAGS)
        |=> s_reg.flags[ULFT_FLG_CRC16])
        else $error("held flag dropped without write");
    chk_port_or: assert property (@(posedge clk_sys) disable iff (sys_rst)
        event_port[0] == |(s_reg.flags & s_reg.masks[6:0]))
        else $error("event port 0 mismatch");
    chk_token_flag: assert property (@(posedge clk_sys) disable iff (sys_rst || soft_rst)
        pkt_in.token_ok && pkt_in.addr == s_reg.dev_addr |=> s_reg.flags[ULFT_FLG_TOKEN])
        else $error("token flag not set");
    chk_ep_capture: assert property (@(posedge clk_sys) disable iff (sys_rst || soft_rst)
        pkt_in.token_ok && addr_hit |=> s_reg.endp[ULFT_EP_VALID] &&
                                        s_reg.endp[3:0] == $past(pkt_in.endp))
        else $error("endpoint not captured");
    chk_ep_mark: assert property (@(posedge clk_sys) disable iff (sys_rst || soft_rst)
        pkt_in.token_ok && addr_hit && s_reg.mark[pkt_in.endp] |=> rx_ep_port[4])
        else $error("marked endpoint missing 0x10");
    chk_reserved_zero: assert property (@(posedge clk_sys) disable iff (sys_rst)
        $past(bus_req.sel && !bus_req.wr && bus_req.addr == ULFT_OFS_IDENT) |->
        bus_rdata[31:4] == 28'h0)
        else $error("reserved bits nonzero");

    // ==========================================================
    // register path checks
    chk_serial_read: assert property (
        bus_req.sel && !bus_req.wr && bus_req.addr == ULFT_OFS_SERIAL && !soft_rst |=>
        bus_rdata == {25'h0, $past(rcv_sync), $past(s_reg.serial)})
        else $error("serial read does not show receivers");

    chk_txen_soft: assert property (
        soft_rst |=> tx_enable_n && !tx_se0 && !tx_level && !fsls_serial)
        else $error("soft reset left tx enabled");

    chk_frame_write: assert property (
        bus_req.sel && bus_req.wr && bus_req.addr == ULFT_OFS_FRAME && !soft_rst |=>
        s_reg.frame == $past(bus_req.wdata[10:0]))
        else $error("frame count write lost");

    chk_ro_write: assert property (
        bus_req.sel && bus_req.wr && bus_req.addr == ULFT_OFS_IDENT &&
        !pkt_in.token_ok && !soft_rst |=> $stable(s_reg.ident))
        else $error("read-only identifier written");

    // ==========================================================
    // flag checks; a packet start only restarts the free flags
    sequence seq_free_start;
        pkt_in.pkt_start && !soft_rst;
    endsequence
    sequence seq_token_hit;
        pkt_in.token_ok && addr_hit && !soft_rst;
    endsequence

    chk_line_k: assert property (
        ls_sync == ULFT_LS_K && !soft_rst |=> s_reg.flags[ULFT_FLG_K])
        else $error("K flag not set");

    chk_crc_flag: assert property (
        pkt_in.crc16_bad && !soft_rst |=> s_reg.flags[ULFT_FLG_CRC16])
        else $error("crc16 flag not set");

    chk_rxact_follow: assert property (
        !s_reg.hold[ULFT_FLG_RXACT] && !soft_rst |=> s_reg.flags[ULFT_FLG_RXACT] == $past(act_sync))
        else $error("receive active flag not following");

    chk_rxerr_follow: assert property (
        !s_reg.hold[ULFT_FLG_RXERR] && !soft_rst |=> s_reg.flags[ULFT_FLG_RXERR] == $past(err_sync))
        else $error("receive error flag not following");

    chk_free_drop: assert property (
        !s_reg.hold[ULFT_FLG_K] && ls_sync != ULFT_LS_K && !soft_rst |=> !s_reg.flags[ULFT_FLG_K])
        else $error("free K flag not dropped");

    chk_free_restart: assert property (
        seq_free_start ##0 !s_reg.hold[ULFT_FLG_CRC16] |=>
        s_reg.flags[ULFT_FLG_CRC16] == $past(pkt_in.crc16_bad))
        else $error("free flag survived packet start");

    chk_hold_clear: assert property (
        s_reg.hold[ULFT_FLG_K] && flag_clr[ULFT_FLG_K] && !flag_set[ULFT_FLG_K] && !soft_rst
        |=> !s_reg.flags[ULFT_FLG_K])
        else $error("held flag not cleared by write");

    // set beats clear, so an event in the clearing cycle is never lost
    chk_set_wins: assert property (
        s_reg.hold[ULFT_FLG_J] && flag_clr[ULFT_FLG_J] && flag_set[ULFT_FLG_J] && !soft_rst
        |=> s_reg.flags[ULFT_FLG_J])
        else $error("clear beat a new event");

    // ==========================================================
    // packet capture checks
    chk_ident_capture: assert property (
        seq_token_hit |=> s_reg.ident == $past(pkt_in.ident))
        else $error("identifier not captured");

    chk_ep_plain: assert property (
        seq_token_hit ##0 !s_reg.mark[pkt_in.endp] |=> rx_ep_port == {4'h0, $past(pkt_in.endp)})
        else $error("unmarked endpoint altered");

    chk_addr_miss: assert property (
        pkt_in.token_ok && pkt_in.addr != s_reg.dev_addr && !soft_rst |=> !pkt_accept)
        else $error("token for another address accepted");
endmodule : ulft_top
`default_nettype wire

// [verif/ulft_phy_model.sv]
// partner model: transceiver receive pins and token engine result pulses
`timescale 1ns/1ps
`default_nettype none
module ulft_phy_model (
    input  wire logic                 clk_sys,   // system clock
    output var  ulft_pkg::ulft_line_t line_out,  // receiver pins
    output var  ulft_pkg::ulft_pkt_t  pkt_out    // token engine results
);
    import ulft_pkg::*;
    // ==========================================================
    // idle bus sits in J with no packet in flight
    initial begin
        line_out = 7'h20;
        pkt_out  = '0;
    end
    // pins are async, so they move whenever the bench asks
    task automatic set_line(input ulft_line_t v);
        line_out = v;
    endtask
    // one-cycle pulse; fields scramble after it since nothing holds them
    task automatic send_pkt(input ulft_pkt_t p);
        pkt_out = p;
        @(negedge clk_sys);
        pkt_out = '{token_ok: 1'b0, ident: ~p.ident, addr: ~p.addr, endp: ~p.endp,
                    crc16_bad: 1'b0, pkt_start: 1'b0};
    endtask
endmodule // ulft_phy_model
`default_nettype wire

// [verif/ulft_top_test.sv]
// testbench: register, flag, event port and packet capture scenarios
`timescale 1ns/1ps
`default_nettype none
module ulft_top_test;
    import ulft_pkg::*;
    // ==========================================================
    // signals and instances
    logic          clk_sys;
    logic          sys_rst;
    logic          soft_rst;
    ulft_bus_req_t bus_req;
    logic [31:0]   bus_rdata;
    ulft_line_t    line_in;
    ulft_pkt_t     pkt_in;
    logic          tx_se0;
    logic          tx_level;
    logic          tx_enable_n;
    logic          fsls_serial;
    logic [3:0]    event_port;
    logic [7:0]    rx_ep_port;
    logic          pkt_accept;
    int            n_errors;
    int            compares;
    ulft_top i_ulft_top (.clk_sys(clk_sys), .sys_rst(sys_rst), .soft_rst(soft_rst),
        .bus_req(bus_req), .bus_rdata(bus_rdata), .line_in(line_in), .pkt_in(pkt_in),
        .tx_se0(tx_se0), .tx_level(tx_level), .tx_enable_n(tx_enable_n),
        .fsls_serial(fsls_serial), .event_port(event_port), .rx_ep_port(rx_ep_port),
        .pkt_accept(pkt_accept));
    ulft_phy_model i_ulft_phy_model (.clk_sys(clk_sys), .line_out(line_in),
        .pkt_out(pkt_in));
    // ==========================================================
    // shared helpers
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic summarize();
        if (n_errors == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic cycles(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    // one whole word per strobe, launched and released on falling edges
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge clk_sys);
        bus_req = '{sel: 1'b1, wr: 1'b1, addr: a, wdata: d};
        @(negedge clk_sys);
        bus_req.sel = 1'b0;
    endtask
    // read data is registered at the strobe edge and holds, so take it at release
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        @(negedge clk_sys);
        bus_req = '{sel: 1'b1, wr: 1'b0, addr: a, wdata: 32'h0};
        @(negedge clk_sys);
        bus_req.sel = 1'b0;
        chk(what, bus_rdata, exp);
    endtask
    task automatic pins_chk(input logic [3:0] exp);
        chk("tx_pins", {28'h0, tx_se0, tx_level, tx_enable_n, fsls_serial}, {28'h0, exp});
    endtask
    // pins cross a 3-flop synchroniser, so give them 6 cycles to land
    task automatic line_step(input ulft_line_t v, input logic [31:0] flags,
                             input logic [3:0] port);
        i_ulft_phy_model.set_line(v);
        cycles(6);
        rd_chk("line_event_flags", ULFT_OFS_FLAGS, flags);
        chk("event_port", {28'h0, event_port}, {28'h0, port});
    endtask
    // ==========================================================
    // scenarios
    task automatic t_reset();
        logic [7:0] ofs [7] = '{ULFT_OFS_ADDR, ULFT_OFS_HOLD, ULFT_OFS_MASKS,
                                ULFT_OFS_FRAME, ULFT_OFS_IDENT, ULFT_OFS_EP, ULFT_OFS_MARK};
        pins_chk(4'h2);
        rd_chk("line_event_flags", ULFT_OFS_FLAGS, 32'h08);
        rd_chk("serial_line_control", ULFT_OFS_SERIAL, 32'h2);
        foreach (ofs[i]) begin
            rd_chk("reset_value", ofs[i], 32'h0);
        end
    endtask
    // reserved bits written high must not stick, read-only bits follow pins
    task automatic t_serial();
        bus_wr(ULFT_OFS_SERIAL, 32'hFFFF_FFFF);
        cycles(2);
        pins_chk(4'hF);
        i_ulft_phy_model.set_line(7'h25);
        cycles(6);
        rd_chk("serial_line_control", ULFT_OFS_SERIAL, 32'h5F);
        bus_wr(ULFT_OFS_SERIAL, 32'hFFFF_FF05);
        cycles(2);
        pins_chk(4'h5);
        i_ulft_phy_model.set_line(7'h12);
        cycles(6);
        rd_chk("serial_line_control", ULFT_OFS_SERIAL, 32'h25);
        bus_wr(ULFT_OFS_SERIAL, 32'h2);
    endtask
    // port0 watches J, port1 K, port2 SE0, port3 receive error
    task automatic t_free();
        bus_wr(ULFT_OFS_MASKS, 32'h0120_1008);
        rd_chk("flag_port_masks", ULFT_OFS_MASKS, 32'h0120_1008);
        line_step(7'h20, 32'h08, 4'h1);
        line_step(7'h50, 32'h12, 4'h2);
        line_step(7'h08, 32'h21, 4'hC);
        line_step(7'h20, 32'h08, 4'h1);
    endtask
    task automatic t_held();
        bus_wr(ULFT_OFS_HOLD, 32'hFFFF_FFFF);
        rd_chk("flag_hold_select", ULFT_OFS_HOLD, 32'h7F);
        line_step(7'h40, 32'h18, 4'h3);
        line_step(7'h20, 32'h18, 4'h3);
        // J is still on the line, so its set beats the clear
        bus_wr(ULFT_OFS_FLAGS, 32'h18);
        rd_chk("line_event_flags", ULFT_OFS_FLAGS, 32'h08);
        // a held crc error must survive the next packet start
        i_ulft_phy_model.send_pkt({1'b0, 4'h0, 7'h00, 4'h0, 2'b10});
        cycles(1);
        i_ulft_phy_model.send_pkt({17'h0, 1'b1});
        rd_chk("line_event_flags", ULFT_OFS_FLAGS, 32'h0C);
        bus_wr(ULFT_OFS_FLAGS, 32'h04);
        bus_wr(ULFT_OFS_HOLD, 32'h0);
    endtask
    // packet fields: token_ok, ident, addr, endp, crc16_bad, pkt_start
    task automatic t_packets();
        bus_wr(ULFT_OFS_ADDR, 32'hFFFF_FF85);
        rd_chk("device_address", ULFT_OFS_ADDR, 32'h05);
        bus_wr(ULFT_OFS_MARK, 32'hFFFF_0008);
        rd_chk("endpoint_mark_select", ULFT_OFS_MARK, 32'h0008);
        i_ulft_phy_model.send_pkt({1'b1, 4'h9, 7'h05, 4'h3, 2'b00});
        chk("pkt_accept", {31'h0, pkt_accept}, 32'h1);
        chk("rx_ep_port", {24'h0, rx_ep_port}, 32'h13);
        rd_chk("last_packet_ident", ULFT_OFS_IDENT, 32'h9);
        rd_chk("last_endpoint_seen", ULFT_OFS_EP, 32'h13);
        rd_chk("line_event_flags", ULFT_OFS_FLAGS, 32'h48);
        i_ulft_phy_model.send_pkt({1'b0, 4'h3, 7'h05, 4'h0, 2'b10});
        rd_chk("line_event_flags", ULFT_OFS_FLAGS, 32'h4C);
        i_ulft_phy_model.send_pkt({17'h0, 1'b1});
        rd_chk("line_event_flags", ULFT_OFS_FLAGS, 32'h08);
        i_ulft_phy_model.send_pkt({1'b1, 4'h9, 7'h06, 4'h2, 2'b00});
        chk("pkt_accept", {31'h0, pkt_accept}, 32'h0);
        rd_chk("line_event_flags", ULFT_OFS_FLAGS, 32'h08);
        i_ulft_phy_model.send_pkt({1'b1, 4'h9, 7'h05, 4'h2, 2'b00});
        chk("pkt_accept", {31'h0, pkt_accept}, 32'h1);
        chk("rx_ep_port", {24'h0, rx_ep_port}, 32'h02);
    endtask
    task automatic t_frame_soft();
        bus_wr(ULFT_OFS_FRAME, 32'hFFFF_FFFF);
        rd_chk("frame_number_count", ULFT_OFS_FRAME, 32'h7FF);
        bus_wr(ULFT_OFS_IDENT, 32'h0);
        rd_chk("last_packet_ident", ULFT_OFS_IDENT, 32'h9);
        bus_wr(ULFT_OFS_EP, 32'h0);
        rd_chk("last_endpoint_seen", ULFT_OFS_EP, 32'h12);
        rd_chk("unmapped", 8'h3C, 32'h0);
        @(negedge clk_sys);
        soft_rst = 1'b1;
        @(negedge clk_sys);
        soft_rst = 1'b0;
        rd_chk("frame_number_count", ULFT_OFS_FRAME, 32'h0);
        rd_chk("device_address", ULFT_OFS_ADDR, 32'h0);
        pins_chk(4'h2);
    endtask
    // ==========================================================
    // clock, main sequence and hang guard
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    initial begin
        sys_rst  = 1'b1;
        soft_rst = 1'b0;
        bus_req  = '0;
        n_errors = 0;
        compares = 0;
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        sys_rst = 1'b0;
        t_reset();
        t_serial();
        t_free();
        t_held();
        t_packets();
        t_frame_soft();
        summarize();
    end
    // a stuck sequence counts as a mismatch rather than hanging the run
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        summarize();
    end
endmodule // ulft_top_test
`default_nettype wire
